// ---- visc_cfg.svh ----
`ifndef VISC_CFG_SVH
`define VISC_CFG_SVH
// Behaviour
// - Enable-set write of 1 enables that interrupt; 0 ignored; reads show enables.
// - Enabled pending interrupts are activated by priority; disabled ones never activate.
// - Enable-clear write of 1 disables that interrupt; reads show enables.
// - Pending-set write of 1 makes that interrupt pending; reads show pending.
// - Pending-set on pending changes nothing; on disabled still sets pending.
// - Pending-clear write of 1 removes pending; reads show pending.
// - Pending-clear never touches the active state.
// - Active register reads 1 for active or active-and-pending interrupts.
// - Each interrupt has priority 0 to 7; smaller is more urgent.
// - Only bits 7:5 of each priority byte stored; bits 4:0 read zero.
// - Priority registers accept byte and word accesses, four fields each.
// - Interrupt N priority sits in register N/4, byte lane N mod 4.
// - Writing a number to the trigger field makes that interrupt pending.
// - Trigger register takes unprivileged writes only while the permit bit is 1.
// - Pending is set by high line while inactive, rising edge, or software.
// - Handler entry moves an interrupt from pending to active.
// - Handler return samples the line: high goes pending, low goes inactive.
// - Pending-clear with line still high leaves state unchanged.
// - Interrupts 0-31 in the first register of each pair, 32-63 the second.

// ==================== Register map (byte addresses in the block)
`define VISC_OFS_ENABLE_SET 12'h100
`define VISC_OFS_ENABLE_CLEAR 12'h180
`define VISC_OFS_PENDING_SET 12'h200
`define VISC_OFS_PENDING_CLEAR 12'h280
`define VISC_OFS_ACTIVE 12'h300
`define VISC_OFS_PRIORITY 12'h400
`define VISC_OFS_TRIGGER 12'hf00
`define VISC_NUM_IRQ 64
`define VISC_PRIO_W 3
`define VISC_PRIO_LSB 5
`define VISC_TRIG_W 9
`define VISC_RESET_WORD 32'h0000_0000
`endif

// ---- visc_pkg.sv ----
package visc_pkg;
  typedef logic [2:0] visc_prio_t;
  typedef logic [5:0] visc_irq_t;
  typedef logic [31:0] visc_word_t;
endpackage : visc_pkg

// ---- visc_prio_mem.sv ----
`timescale 1ns/1ps
`include "visc_cfg.svh"
module visc_prio_mem (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [3:0] wr_lane_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [3:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  output logic [`VISC_NUM_IRQ*3-1:0] prio_flat_o
);
  logic [2:0] mem_r [0:`VISC_NUM_IRQ-1];

  genvar g;
  generate
    for (g = 0; g < `VISC_NUM_IRQ; g = g + 1) begin : g_ent
      wire sel_w = (wr_idx_i == 4'(g / 4)) && wr_lane_i[g % 4];
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          mem_r[g] <= 3'h0;
        end else if (sel_w) begin
          mem_r[g] <= wr_data_i[(g % 4) * 8 + `VISC_PRIO_LSB +: `VISC_PRIO_W];
        end
      end
      assign prio_flat_o[g*3 +: 3] = mem_r[g];
    end
  endgenerate

  // ==================== Registered read port
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 32'h0;
    end else begin
      rd_data_o <= {mem_r[{rd_idx_i, 2'h3}], 5'h0, mem_r[{rd_idx_i, 2'h2}], 5'h0,
                    mem_r[{rd_idx_i, 2'h1}], 5'h0, mem_r[{rd_idx_i, 2'h0}], 5'h0};
    end
  end
endmodule : visc_prio_mem

// ---- visc_state_ctrl.sv ----
`timescale 1ns/1ps
`include "visc_cfg.svh"
module visc_state_ctrl (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [63:0] irq_line_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_priv_i,
  input wire logic unprivileged_pend_permit_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_err_o,
  input wire logic entry_i,
  input wire visc_pkg::visc_irq_t entry_irq_i,
  input wire logic return_i,
  input wire visc_pkg::visc_irq_t return_irq_i,
  output logic req_valid_o,
  output visc_pkg::visc_irq_t req_irq_o,
  output visc_pkg::visc_prio_t req_prio_o
);
  import visc_pkg::*;

  // ==================== Line synchronisers
  logic [63:0] line_s1_r;
  logic [63:0] line_s2_r;
  logic [63:0] line_prev_r;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_s1_r <= 64'h0;
      line_s2_r <= 64'h0;
      line_prev_r <= 64'h0;
    end else begin
      line_s1_r <= irq_line_i;
      line_s2_r <= line_s1_r;
      line_prev_r <= line_s2_r;
    end
  end

  // ==================== Bus decode
  logic [63:0] enable_r;
  logic [63:0] pending_r;
  logic [63:0] active_r;
  wire [11:0] base_w = {reg_addr_i[11:3], 3'h0};
  wire word_w = reg_addr_i[2];
  wire wr_w = reg_sel_i && reg_wr_i;
  wire aligned_w = (reg_addr_i[1:0] == 2'h0);
  wire wfull_w = wr_w && aligned_w && (reg_be_i == 4'hf);
  wire hit_es_w = base_w == `VISC_OFS_ENABLE_SET;
  wire hit_ec_w = base_w == `VISC_OFS_ENABLE_CLEAR;
  wire hit_ps_w = base_w == `VISC_OFS_PENDING_SET;
  wire hit_pc_w = base_w == `VISC_OFS_PENDING_CLEAR;
  wire hit_ac_w = base_w == `VISC_OFS_ACTIVE;
  wire hit_pr_w = reg_addr_i[11:6] == 6'(`VISC_OFS_PRIORITY >> 6);
  wire hit_tr_w = reg_addr_i == `VISC_OFS_TRIGGER;
  wire hit_any_w = hit_es_w || hit_ec_w || hit_ps_w || hit_pc_w || hit_ac_w
                   || hit_pr_w || hit_tr_w;
  wire [63:0] wmask_w = word_w ? {reg_wdata_i, 32'h0} : {32'h0, reg_wdata_i};
  wire [63:0] en_set_w = (wfull_w && hit_es_w) ? wmask_w : 64'h0;
  wire [63:0] en_clr_w = (wfull_w && hit_ec_w) ? wmask_w : 64'h0;
  wire trig_ok_w = wfull_w && hit_tr_w && (reg_priv_i || unprivileged_pend_permit_i);
  wire [8:0] trig_num_w = reg_wdata_i[`VISC_TRIG_W-1:0];
  wire [63:0] trig_w = (trig_ok_w && trig_num_w < 9'(`VISC_NUM_IRQ))
                       ? (64'h1 << trig_num_w[5:0]) : 64'h0;
  wire [63:0] pnd_set_w = ((wfull_w && hit_ps_w) ? wmask_w : 64'h0) | trig_w;
  wire [63:0] pnd_clr_w = (wfull_w && hit_pc_w) ? wmask_w : 64'h0;
  wire [63:0] entry_w = entry_i ? (64'h1 << entry_irq_i) : 64'h0;
  wire [63:0] ret_w = return_i ? (64'h1 << return_irq_i) : 64'h0;
  // Entry masks the level term, else a held line re-pends at handler entry
  wire [63:0] hw_set_w = (line_s2_r & ~(active_r | entry_w)) | (line_s2_r & ~line_prev_r);
  wire pr_wr_w = wr_w && aligned_w && hit_pr_w && reg_priv_i;

  // ==================== State update
  wire [63:0] pnd_nxt = (pending_r & ~(pnd_clr_w & ~line_s2_r) & ~entry_w)
                        | pnd_set_w | hw_set_w | (ret_w & line_s2_r);
  wire [63:0] act_nxt = (active_r | entry_w) & ~ret_w;
  wire [63:0] en_nxt = (enable_r | en_set_w) & ~en_clr_w;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_r <= 64'h0;
      pending_r <= 64'h0;
      active_r <= 64'h0;
    end else if (reg_priv_i || !wr_w || hit_tr_w) begin
      enable_r <= en_nxt;
      pending_r <= pnd_nxt;
      active_r <= act_nxt;
    end else begin
      pending_r <= (pending_r & ~entry_w) | hw_set_w | (ret_w & line_s2_r);
      active_r <= act_nxt;
    end
  end

  // ==================== Priority storage
  logic [`VISC_NUM_IRQ*3-1:0] prio_flat_w;
  logic [31:0] prio_rd_w;
  visc_prio_mem u_prio (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .wr_idx_i(pr_wr_w ? reg_addr_i[5:2] : 4'h0),
    .wr_lane_i(pr_wr_w ? reg_be_i : 4'h0),
    .wr_data_i(reg_wdata_i),
    .rd_idx_i(reg_addr_i[5:2]),
    .rd_data_o(prio_rd_w),
    .prio_flat_o(prio_flat_w)
  );

  // ==================== Arbitration
  wire [63:0] cand_w = pending_r & enable_r & ~active_r;
  always_comb begin
    logic [2:0] best;
    best = 3'h7;
    req_valid_o = 1'b0;
    req_irq_o = 6'h0;
    for (int i = 0; i < `VISC_NUM_IRQ; i++) begin
      if (cand_w[i] && (!req_valid_o || prio_flat_w[i*3 +: 3] < best)) begin
        req_valid_o = 1'b1;
        req_irq_o = 6'(i);
        best = prio_flat_w[i*3 +: 3];
      end
    end
    req_prio_o = best;
  end

  // ==================== Read data
  // Priority read comes registered, so all reads answer one cycle late
  logic rd_pr_r;
  logic [31:0] rd_r;
  logic err_r;
  wire [63:0] rd_src_w = (hit_es_w || hit_ec_w) ? enable_r :
                         (hit_ps_w || hit_pc_w) ? pending_r :
                         hit_ac_w ? active_r : 64'h0;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_r <= `VISC_RESET_WORD;
      rd_pr_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rd_r <= word_w ? rd_src_w[63:32] : rd_src_w[31:0];
      rd_pr_r <= hit_pr_w;
      err_r <= reg_sel_i && (!hit_any_w || !aligned_w ||
               (!reg_priv_i && !hit_tr_w) || (hit_tr_w && !reg_wr_i) ||
               (hit_tr_w && !reg_priv_i && !unprivileged_pend_permit_i));
    end
  end
  assign reg_rdata_o = rd_pr_r ? prio_rd_w : rd_r;
  assign reg_err_o = err_r;
endmodule : visc_state_ctrl

// ---- visc_monitor.sv ----
`timescale 1ns/1ps
// ====================
// Port checks
module visc_monitor (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_priv_i,
  input wire logic unprivileged_pend_permit_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_err_o,
  input wire logic entry_i,
  input wire visc_pkg::visc_irq_t entry_irq_i,
  input wire logic req_valid_o,
  input wire visc_pkg::visc_irq_t req_irq_o
);
  import visc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic rd_q;
  assign rd_q = reg_sel_i && !reg_wr_i;
  property p_err_cause; reg_err_o |-> $past(reg_sel_i); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error without access");
  property p_misalign; reg_sel_i && reg_addr_i[1:0] != 2'h0 |=> reg_err_o; endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned access taken");
  property p_trig_rd; rd_q && reg_addr_i == 12'hf00 |=> reg_err_o; endproperty
  a_trig_rd: assert property (p_trig_rd) else $error("trigger read taken");
  property p_unpriv; reg_sel_i && !reg_priv_i && reg_addr_i != 12'hf00 |=> reg_err_o; endproperty
  a_unpriv: assert property (p_unpriv) else $error("unprivileged access taken");
  property p_trig_deny;
    reg_sel_i && reg_wr_i && !reg_priv_i && !unprivileged_pend_permit_i
      && reg_addr_i == 12'hf00 |=> reg_err_o;
  endproperty
  a_trig_deny: assert property (p_trig_deny) else $error("trigger without permit");
  property p_prio_low;
    rd_q && reg_priv_i && reg_addr_i[11:6] == 6'h10 |=> (reg_rdata_o & 32'h1f1f1f1f) == 32'h0;
  endproperty
  a_prio_low: assert property (p_prio_low) else $error("priority low bits set");
  property p_en_ok; rd_q && reg_priv_i && reg_addr_i == 12'h100 |=> !reg_err_o; endproperty
  a_en_ok: assert property (p_en_ok) else $error("enable read refused");
  property p_entry; entry_i |=> !(req_valid_o && req_irq_o == $past(entry_irq_i)); endproperty
  a_entry: assert property (p_entry) else $error("active irq still offered");
  c_entry: cover property (entry_i);
  c_err: cover property (reg_err_o);
  c_req: cover property (req_valid_o);
endmodule : visc_monitor

// ---- visc_src_model.sv ----
`timescale 1ns/1ps
// ====================
// Peripheral sources
module visc_src_model (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [63:0] raise_i,
  input wire logic [63:0] service_i,
  output logic [63:0] line_o
);
  // Level held until the handler services the peripheral
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) line_o <= '0;
    else line_o <= (line_o | raise_i) & ~service_i;
  end
endmodule : visc_src_model

// ---- vectored_interrupt_state_control_tb_top.sv ----
`timescale 1ns/1ps
module vectored_interrupt_state_control_tb_top;
  import visc_pkg::*;
  typedef struct {logic [11:0] wa; logic [3:0] b; logic [31:0] wd; logic [11:0] ra;
    logic [31:0] e;} visc_row_t;
  logic clk_sys_i = 0, reset_n_i = 0, sel = 0, wr = 0, priv = 1, permit = 0, ent = 0, ret = 0;
  logic [11:0] addr = '0;
  logic [3:0] be = '0;
  logic [31:0] wd = '0, rd;
  logic [63:0] raise = '0, svc = '0, line;
  visc_irq_t ent_irq = '0, ret_irq = '0, req_irq;
  visc_prio_t req_prio;
  logic err, req_v;
  int err_count = 0, num_checks = 0, cyc = 0;
  visc_row_t rows [9] = '{
    '{12'h100, 4'hf, 32'h5, 12'h100, 32'h5},
    '{12'h180, 4'hf, 32'h1, 12'h180, 32'h4},
    '{12'h104, 4'hf, 32'h80000000, 12'h184, 32'h80000000},
    '{12'h200, 4'hf, 32'h10, 12'h280, 32'h10},
    '{12'h200, 4'hf, 32'h10, 12'h200, 32'h10},
    '{12'h280, 4'hf, 32'h10, 12'h200, 32'h0},
    '{12'h400, 4'hf, 32'hffffffff, 12'h400, 32'he0e0e0e0},
    '{12'h404, 4'h2, 32'h4000, 12'h404, 32'h4000},
    '{12'h200, 4'hf, 32'h0, 12'h300, 32'h0}};
  visc_state_ctrl u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .irq_line_i(line),
    .reg_sel_i(sel), .reg_wr_i(wr), .reg_addr_i(addr), .reg_be_i(be), .reg_wdata_i(wd),
    .reg_priv_i(priv), .unprivileged_pend_permit_i(permit), .reg_rdata_o(rd), .reg_err_o(err),
    .entry_i(ent), .entry_irq_i(ent_irq), .return_i(ret), .return_irq_i(ret_irq),
    .req_valid_o(req_v), .req_irq_o(req_irq), .req_prio_o(req_prio));
  visc_src_model u_src (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .raise_i(raise),
    .service_i(svc), .line_o(line));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_sys_i);
    {sel, wr, addr, be, wd} = {1'b1, w, a, b, d};
    @(negedge clk_sys_i);
    sel = 0;
  endtask : acc
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    acc(0, a, 4'hf, 32'h0);
    chk("rdata", e, rd);
  endtask : rdchk
  task automatic src(input logic [63:0] r, input logic [63:0] s);
    @(negedge clk_sys_i);
    {raise, svc} = {r, s};
    @(negedge clk_sys_i);
    {raise, svc} = '0;
    repeat (5) @(negedge clk_sys_i);
  endtask : src
  task automatic core(input logic e, input visc_irq_t n);
    @(negedge clk_sys_i);
    {ent, ret, ent_irq, ret_irq} = {e, !e, n, n};
    @(negedge clk_sys_i);
    {ent, ret} = 2'h0;
  endtask : core
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1;
    rdchk(12'h100, 32'h0);
    foreach (rows[i]) begin
      acc(1, rows[i].wa, rows[i].b, rows[i].wd);
      rdchk(rows[i].ra, rows[i].e);
    end
    src(64'h4, 64'h0);
    chk("req", 32'h3c2, {22'h0, req_prio, req_v, req_irq});
    rdchk(12'h200, 32'h4);
    core(1, 6'h2);
    rdchk(12'h300, 32'h4);
    rdchk(12'h200, 32'h0);
    src(64'h0, 64'h4);
    acc(1, 12'h200, 4'hf, 32'h4);
    acc(1, 12'h280, 4'hf, 32'h4);
    rdchk(12'h300, 32'h4);
    core(0, 6'h2);
    rdchk(12'h300, 32'h0);
    src(64'h4, 64'h0);
    core(1, 6'h2);
    core(0, 6'h2);
    rdchk(12'h200, 32'h4);
    core(1, 6'h2);
    acc(1, 12'h200, 4'hf, 32'h4);
    acc(1, 12'h280, 4'hf, 32'h4);
    rdchk(12'h200, 32'h4);
    core(0, 6'h2);
    src(64'h0, 64'h4);
    acc(1, 12'h280, 4'hf, 32'h6);
    acc(1, 12'h200, 4'hf, 32'h2);
    rdchk(12'h200, 32'h2);
    chk("req", 32'h0, {31'h0, req_v});
    acc(0, 12'h102, 4'hf, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    acc(0, 12'h010, 4'hf, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    acc(0, 12'hf00, 4'hf, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    priv = 0;
    acc(1, 12'hf00, 4'hf, 32'h3);
    chk("err", 32'h1, {31'h0, err});
    acc(0, 12'h100, 4'hf, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    permit = 1;
    acc(1, 12'hf00, 4'hf, 32'h3);
    chk("err", 32'h0, {31'h0, err});
    priv = 1;
    rdchk(12'h200, 32'ha);
    acc(1, 12'h100, 4'hf, 32'h24);
    acc(1, 12'h200, 4'hf, 32'h24);
    chk("req", 32'h145, {22'h0, req_prio, req_v, req_irq});
    print_verdict();
  end
endmodule : vectored_interrupt_state_control_tb_top
bind visc_state_ctrl visc_monitor u_mon (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_priv_i(reg_priv_i),
  .unprivileged_pend_permit_i(unprivileged_pend_permit_i), .reg_rdata_o(reg_rdata_o),
  .reg_err_o(reg_err_o), .entry_i(entry_i), .entry_irq_i(entry_irq_i),
  .req_valid_o(req_valid_o), .req_irq_o(req_irq_o));
